/* File: hw/qcrb_chan_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module qcrb_chan_mem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [8:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic re,
	input wire logic [8:0] raddr,
	output logic [7:0] rdata
);
	import qcrb_pkg::*;
	// ==================================================
	// storage: one bank of offsets for each channel
	logic [7:0] mem [0:511];

	// no reset on the array: software programs every copy before use
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= RST_BYTE;
		end else if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

/* File: hw/qcrb_pkg.sv */
package qcrb_pkg;
	// ==================================================
	// global register offsets
	localparam logic [6:0] OFS_FIRMWARE_REVISION = 7'h40;
	localparam logic [6:0] OFS_CHANNEL_SELECT = 7'h68;
	localparam logic [6:0] OFS_GLOBAL_CONFIG = 7'h4B;
	localparam logic [6:0] OFS_SERVICE_REQUEST_STATUS = 7'h67;
	localparam logic [6:0] OFS_RX_INT_CHANNEL = 7'h44;
	localparam logic [6:0] OFS_TX_INT_CHANNEL = 7'h45;
	localparam logic [6:0] OFS_MODEM_INT_CHANNEL = 7'h46;
	localparam logic [6:0] OFS_RX_INT_REQUEST = 7'h6B;
	localparam logic [6:0] OFS_TX_INT_REQUEST = 7'h6A;
	localparam logic [6:0] OFS_MODEM_INT_REQUEST = 7'h69;
	localparam logic [6:0] OFS_PRESCALER_PERIOD = 7'h7E;
	// ==================================================
	// virtual register offsets
	localparam logic [6:0] OFS_RX_INT_VECTOR = 7'h43;
	localparam logic [6:0] OFS_TX_INT_VECTOR = 7'h42;
	localparam logic [6:0] OFS_MODEM_INT_VECTOR = 7'h41;
	localparam logic [6:0] OFS_TX_DATA = 7'h63;
	localparam logic [6:0] OFS_RX_DATA_STATUS = 7'h62;
	localparam logic [6:0] OFS_MODEM_INT_STATUS = 7'h4C;
	localparam logic [6:0] OFS_END_OF_SERVICE = 7'h60;
	// ==================================================
	// per-channel register offsets
	localparam logic [6:0] OFS_LOCAL_INTERRUPT_VECTOR = 7'h18;
	localparam logic [6:0] OFS_CHANNEL_COMMAND = 7'h05;
	localparam logic [6:0] OFS_SERVICE_REQUEST_ENABLE = 7'h06;
	localparam logic [6:0] OFS_CHANNEL_OPTION_1 = 7'h08;
	localparam logic [6:0] OFS_CHANNEL_OPTION_2 = 7'h09;
	localparam logic [6:0] OFS_CHANNEL_OPTION_3 = 7'h0A;
	localparam logic [6:0] OFS_CHANNEL_OPTION_4 = 7'h1E;
	localparam logic [6:0] OFS_CHANNEL_OPTION_5 = 7'h1F;
	localparam logic [6:0] OFS_CHANNEL_CONTROL_STATUS = 7'h0B;
	localparam logic [6:0] OFS_RECEIVED_DATA_COUNT = 7'h0E;
	localparam logic [6:0] OFS_SPECIAL_CHAR_1 = 7'h1A;
	localparam logic [6:0] OFS_SPECIAL_CHAR_2 = 7'h1B;
	localparam logic [6:0] OFS_SPECIAL_CHAR_3 = 7'h1C;
	localparam logic [6:0] OFS_SPECIAL_CHAR_4 = 7'h1D;
	localparam logic [6:0] OFS_SPECIAL_RANGE_LOW = 7'h22;
	localparam logic [6:0] OFS_SPECIAL_RANGE_HIGH = 7'h23;
	localparam logic [6:0] OFS_LITERAL_NEXT_CHAR = 7'h24;
	localparam logic [6:0] OFS_MODEM_CHANGE_OPTION_1 = 7'h15;
	localparam logic [6:0] OFS_MODEM_CHANGE_OPTION_2 = 7'h16;
	localparam logic [6:0] OFS_RECEIVE_TIMEOUT_PERIOD = 7'h21;
	localparam logic [6:0] OFS_MODEM_SIGNAL_VALUE_1 = 7'h6C;
	localparam logic [6:0] OFS_MODEM_SIGNAL_VALUE_2 = 7'h6D;
	localparam logic [6:0] OFS_PRINTER_SIGNAL_VALUE = 7'h6F;
	localparam logic [6:0] OFS_RX_RATE_PERIOD = 7'h78;
	localparam logic [6:0] OFS_RX_CLOCK_OPTION = 7'h7C;
	localparam logic [6:0] OFS_TX_RATE_PERIOD = 7'h72;
	localparam logic [6:0] OFS_TX_CLOCK_OPTION = 7'h76;
	// ==================================================
	// fields and reset values
	localparam int GCR_PARALLEL_BIT = 7;
	localparam int NUM_CHANNELS = 4;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] FIRMWARE_CODE_DEFAULT = 8'hA5;
	// ==================================================
	// carriers
	typedef enum logic [1:0] {QCRB_CTX_RX, QCRB_CTX_TX, QCRB_CTX_MODEM} qcrb_ctx_t;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} qcrb_req_t;
	typedef struct packed {
		logic start;
		qcrb_ctx_t kind;
		logic [2:0] vector;
		logic [3:0] modem_change;
	} qcrb_svc_t;
	typedef struct packed {
		logic valid;
		logic [1:0] chan;
		logic [6:0] offset;
		logic [7:0] data;
	} qcrb_cfg_wr_t;
endpackage

/* File: hw/qcrb_top.sv */
// How it works
// - global offsets decode regardless of channel select
// - virtual registers meaningful only inside service context
// - four separate per-channel register copies
// - channel select number routes per-channel offsets
// - selection holds until channel select rewritten
// - seven address bits pick exactly one register
// - channel 0 parallel mode swaps dual meanings
// - offset 40 reads firmware revision code
// - vector registers 43/42/41 read-only virtual
// - offset 60 write ends service context
// - offset 4C reads modem change status
// - interrupting channel registers 44/45/46 read/write
// - per-channel status 0B and count 0E read-only
// - per-channel rx/tx rate periods 78/72
`timescale 1ns/10ps
`default_nettype none
module qcrb_top #(
	parameter logic [7:0] FIRMWARE_CODE = qcrb_pkg::FIRMWARE_CODE_DEFAULT // arbitrary value
) (
	input wire logic clk,
	input wire logic rstn,
	input wire qcrb_pkg::qcrb_req_t host_req,
	output logic [7:0] host_rdata,
	output logic host_rdata_valid,
	input wire qcrb_pkg::qcrb_svc_t svc_in,
	input wire logic [2:0] svc_pending,
	input wire logic [7:0] rx_data,
	input wire logic [31:0] chan_status,
	input wire logic [31:0] chan_rx_count,
	input wire logic [15:0] modem_pins,
	input wire logic [7:0] printer_pins,
	output logic svc_active,
	output logic eos_pulse,
	output logic tx_data_valid,
	output logic [7:0] tx_data,
	output logic rx_pop,
	output logic [1:0] chan_select,
	output logic chan0_parallel,
	output logic [7:0] prescaler_period,
	output var qcrb_pkg::qcrb_cfg_wr_t cfg_wr
);
	import qcrb_pkg::*;

	// ==================================================
	// reset release and pin synchronisers
	logic [1:0] rst_sync;
	logic rst_n;
	logic [23:0] pin_meta;
	logic [23:0] pin_sync;

	// assert at once, release after two clean edges
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// modem and printer lines pass through two synchroniser flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 24'h000000;
			pin_sync <= 24'h000000;
		end else begin
			pin_meta <= {printer_pins, modem_pins};
			pin_sync <= pin_meta;
		end
	end

	// ==================================================
	// decode functions
	// per-channel offsets that software may write and read back
	function automatic logic is_chan_rw(input logic [6:0] a);
		unique case (a)
			OFS_LOCAL_INTERRUPT_VECTOR, OFS_CHANNEL_COMMAND, OFS_SERVICE_REQUEST_ENABLE,
			OFS_CHANNEL_OPTION_1, OFS_CHANNEL_OPTION_2, OFS_CHANNEL_OPTION_3,
			OFS_CHANNEL_OPTION_4, OFS_CHANNEL_OPTION_5, OFS_SPECIAL_CHAR_1,
			OFS_SPECIAL_CHAR_2, OFS_SPECIAL_CHAR_3, OFS_SPECIAL_CHAR_4,
			OFS_SPECIAL_RANGE_LOW, OFS_SPECIAL_RANGE_HIGH, OFS_LITERAL_NEXT_CHAR,
			OFS_MODEM_CHANGE_OPTION_1, OFS_MODEM_CHANGE_OPTION_2,
			OFS_RECEIVE_TIMEOUT_PERIOD, OFS_MODEM_SIGNAL_VALUE_1,
			OFS_MODEM_SIGNAL_VALUE_2, OFS_PRINTER_SIGNAL_VALUE,
			OFS_RX_RATE_PERIOD, OFS_RX_CLOCK_OPTION,
			OFS_TX_RATE_PERIOD, OFS_TX_CLOCK_OPTION: is_chan_rw = 1'b1;
			default: is_chan_rw = 1'b0;
		endcase
	endfunction

	// true when the vector read matches the open context type
	function automatic logic ctx_is(input logic act, input qcrb_ctx_t k, input qcrb_ctx_t want);
		ctx_is = act && (k == want);
	endfunction

	// ==================================================
	// global registers
	logic [7:0] channel_select;
	logic [7:0] global_config;
	logic [7:0] rx_int_channel;
	logic [7:0] tx_int_channel;
	logic [7:0] modem_int_channel;
	logic [7:0] rx_int_request;
	logic [7:0] tx_int_request;
	logic [7:0] modem_int_request;
	logic wr;
	logic rd;
	logic [6:0] addr;

	assign wr = host_req.wr;
	assign rd = host_req.rd && !host_req.wr;
	assign addr = host_req.addr;

	// decoded on the full offset, never on the selected channel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_select <= RST_BYTE;
			global_config <= RST_BYTE;
			rx_int_channel <= RST_BYTE;
			tx_int_channel <= RST_BYTE;
			modem_int_channel <= RST_BYTE;
			rx_int_request <= RST_BYTE;
			tx_int_request <= RST_BYTE;
			modem_int_request <= RST_BYTE;
			prescaler_period <= RST_BYTE;
		end else if (wr) begin
			unique case (addr)
				OFS_CHANNEL_SELECT: channel_select <= host_req.wdata;
				OFS_GLOBAL_CONFIG: global_config <= host_req.wdata;
				OFS_RX_INT_CHANNEL: rx_int_channel <= host_req.wdata;
				OFS_TX_INT_CHANNEL: tx_int_channel <= host_req.wdata;
				OFS_MODEM_INT_CHANNEL: modem_int_channel <= host_req.wdata;
				OFS_RX_INT_REQUEST: rx_int_request <= host_req.wdata;
				OFS_TX_INT_REQUEST: tx_int_request <= host_req.wdata;
				OFS_MODEM_INT_REQUEST: modem_int_request <= host_req.wdata;
				OFS_PRESCALER_PERIOD: prescaler_period <= host_req.wdata;
				default: begin
				end
			endcase
		end
	end

	// only the low two bits pick the bank; upper bits are just stored
	assign chan_select = channel_select[1:0];
	assign chan0_parallel = global_config[GCR_PARALLEL_BIT];

	// ==================================================
	// service request context
	qcrb_ctx_t svc_kind;
	logic [2:0] svc_vector;
	logic [3:0] svc_change;
	logic eos_hit;

	assign eos_hit = wr && (addr == OFS_END_OF_SERVICE);

	// a new context arriving with the closing write wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			svc_active <= 1'b0;
			svc_kind <= QCRB_CTX_RX;
			svc_vector <= 3'h0;
			svc_change <= 4'h0;
		end else if (svc_in.start) begin
			svc_active <= 1'b1;
			svc_kind <= svc_in.kind;
			svc_vector <= svc_in.vector;
			svc_change <= svc_in.modem_change;
		end else if (eos_hit) begin
			svc_active <= 1'b0;
		end
	end

	// ==================================================
	// strobes toward the data paths
	// tx data and rx pops only count inside the matching context
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eos_pulse <= 1'b0;
			tx_data_valid <= 1'b0;
			tx_data <= RST_BYTE;
			rx_pop <= 1'b0;
		end else begin
			eos_pulse <= eos_hit && svc_active;
			tx_data_valid <= wr && (addr == OFS_TX_DATA) && ctx_is(svc_active, svc_kind,
				QCRB_CTX_TX);
			rx_pop <= rd && (addr == OFS_RX_DATA_STATUS) && ctx_is(svc_active, svc_kind,
				QCRB_CTX_RX);
			if (wr && (addr == OFS_TX_DATA)) begin
				tx_data <= host_req.wdata;
			end
		end
	end

	// ==================================================
	// per-channel storage
	logic mem_we;
	logic [7:0] mem_rdata;

	// read-only and unmapped offsets never reach the array
	assign mem_we = wr && is_chan_rw(addr);

	qcrb_chan_mem u_mem (
		.clk(clk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr({chan_select, addr}),
		.wdata(host_req.wdata),
		.re(rd),
		.raddr({chan_select, addr}),
		.rdata(mem_rdata)
	);

	// core shadows channel settings from this write notice
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_wr <= '0;
		end else begin
			cfg_wr.valid <= mem_we;
			cfg_wr.chan <= chan_select;
			cfg_wr.offset <= addr;
			cfg_wr.data <= host_req.wdata;
		end
	end

	// ==================================================
	// read path, stage one: decode and capture live values
	logic rd_pend;
	logic rd_mem;
	logic [1:0] rd_mix;
	logic [7:0] rd_val;
	logic [7:0] next_rd_val;
	logic [1:0] next_rd_mix;
	logic [3:0] sel_modem;
	logic par_mode;

	assign sel_modem = pin_sync[chan_select*4 +: 4];
	assign par_mode = chan0_parallel && (chan_select == 2'h0);

	// mix codes: 0 plain, 1 live pins in upper nibble over stored bits
	always_comb begin
		next_rd_val = RST_BYTE;
		next_rd_mix = 2'h0;
		unique case (addr)
			OFS_FIRMWARE_REVISION: next_rd_val = FIRMWARE_CODE;
			OFS_CHANNEL_SELECT: next_rd_val = channel_select;
			OFS_GLOBAL_CONFIG: next_rd_val = global_config;
			OFS_SERVICE_REQUEST_STATUS: next_rd_val = {5'h00, svc_pending};
			OFS_RX_INT_CHANNEL: next_rd_val = rx_int_channel;
			OFS_TX_INT_CHANNEL: next_rd_val = tx_int_channel;
			OFS_MODEM_INT_CHANNEL: next_rd_val = modem_int_channel;
			OFS_RX_INT_REQUEST: next_rd_val = rx_int_request;
			OFS_TX_INT_REQUEST: next_rd_val = tx_int_request;
			OFS_MODEM_INT_REQUEST: next_rd_val = modem_int_request;
			OFS_PRESCALER_PERIOD: next_rd_val = prescaler_period;
			OFS_RX_INT_VECTOR: begin
				if (ctx_is(svc_active, svc_kind, QCRB_CTX_RX)) begin
					next_rd_val = {5'h00, svc_vector};
				end
			end
			OFS_TX_INT_VECTOR: begin
				if (ctx_is(svc_active, svc_kind, QCRB_CTX_TX)) begin
					next_rd_val = {5'h00, svc_vector};
				end
			end
			OFS_MODEM_INT_VECTOR: begin
				if (ctx_is(svc_active, svc_kind, QCRB_CTX_MODEM)) begin
					next_rd_val = {5'h00, svc_vector};
				end
			end
			OFS_MODEM_INT_STATUS: begin
				if (ctx_is(svc_active, svc_kind, QCRB_CTX_MODEM)) begin
					next_rd_val = {svc_change, 4'h0};
				end
			end
			OFS_RX_DATA_STATUS: begin
				if (ctx_is(svc_active, svc_kind, QCRB_CTX_RX)) begin
					next_rd_val = rx_data;
				end
			end
			OFS_CHANNEL_CONTROL_STATUS: next_rd_val = chan_status[chan_select*8 +: 8];
			OFS_RECEIVED_DATA_COUNT: next_rd_val = chan_rx_count[chan_select*8 +: 8];
			OFS_MODEM_SIGNAL_VALUE_1: begin
				// serial meaning shows the modem lines, parallel the printer inputs
				next_rd_mix = 2'h1;
				next_rd_val = par_mode ? {pin_sync[23:20], 4'h0} :
					{sel_modem, 4'h0};
			end
			OFS_PRINTER_SIGNAL_VALUE: begin
				next_rd_mix = par_mode ? 2'h1 : 2'h0;
				next_rd_val = {pin_sync[23:20], 4'h0};
			end
			default: next_rd_val = RST_BYTE;
		endcase
	end

	// stage one registers line up with the memory read latency
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend <= 1'b0;
			rd_mem <= 1'b0;
			rd_mix <= 2'h0;
			rd_val <= RST_BYTE;
		end else begin
			rd_pend <= rd;
			rd_mem <= is_chan_rw(addr);
			rd_mix <= next_rd_mix;
			rd_val <= next_rd_val;
		end
	end

	// ==================================================
	// read path, stage two: registered answer
	logic [7:0] next_host_rdata;

	// stored channel bytes unless the offset carries live bits
	always_comb begin
		next_host_rdata = rd_val;
		if (rd_mem) begin
			if (rd_mix == 2'h1) begin
				next_host_rdata = {rd_val[7:4], mem_rdata[3:0]};
			end else begin
				next_host_rdata = mem_rdata;
			end
		end
	end

	// the answer byte holds until the next read completes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_rdata <= RST_BYTE;
			host_rdata_valid <= 1'b0;
		end else begin
			host_rdata_valid <= rd_pend;
			if (rd_pend) begin
				host_rdata <= next_host_rdata;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/qcrb_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// host cpu model doing byte-wide register cycles
module qcrb_host
	import qcrb_pkg::*;
(
	input wire logic clk,
	output var qcrb_pkg::qcrb_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic host_rdata_valid
);
	import qcrb_pkg::*;
	initial host_req = '0;
	// released lines show the inverse so a stale value never passes
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge clk);
		host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// answer awaited under a bound; a missing one returns unknown
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk);
		host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clk);
		host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
		for (int n = 0; n < 4 && host_rdata_valid !== 1'b1; n++) @(negedge clk);
		d = (host_rdata_valid === 1'b1) ? host_rdata : 8'hXX;
	endtask
endmodule
`default_nettype wire

/* File: tb/qcrb_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// port-level checker for the register bank
module qcrb_top_sva
	import qcrb_pkg::*;
#(
	parameter logic [7:0] FIRMWARE_CODE = qcrb_pkg::FIRMWARE_CODE_DEFAULT
) (
	input wire logic clk,
	input wire logic rstn,
	input wire qcrb_pkg::qcrb_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic host_rdata_valid,
	input wire qcrb_pkg::qcrb_svc_t svc_in,
	input wire logic svc_active,
	input wire logic eos_pulse,
	input wire logic [1:0] chan_select,
	input wire logic chan0_parallel,
	input wire qcrb_pkg::qcrb_cfg_wr_t cfg_wr
);
	// write wins over read, so a read counts only when write is low
	wire logic is_rd = host_req.rd & ~host_req.wr;
	wire logic is_wr = host_req.wr;
	wire logic eos_req = svc_active & is_wr & (host_req.addr == 7'h60);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ==========
	// read path
	rd_answer_a: assert property (is_rd |-> ##2 host_rdata_valid)
		else $error("read answer missing");
	rd_cause_a: assert property (host_rdata_valid |-> $past(is_rd, 2))
		else $error("read answer without request");
	fw_code_a: assert property (is_rd && host_req.addr == 7'h40 |-> ##2
		host_rdata == FIRMWARE_CODE)
		else $error("firmware code wrong");
	// ==========
	// bank switching and mode
	sel_set_a: assert property (is_wr && host_req.addr == 7'h68 |=>
		chan_select == $past(host_req.wdata[1:0]))
		else $error("channel select not taken");
	sel_hold_a: assert property (!(is_wr && host_req.addr == 7'h68) |=>
		$stable(chan_select))
		else $error("channel select moved");
	par_mode_a: assert property (is_wr && host_req.addr == 7'h4B |=>
		chan0_parallel == $past(host_req.wdata[7]))
		else $error("parallel mode wrong");
	// ==========
	// service context
	svc_open_a: assert property (svc_in.start |=> svc_active)
		else $error("context not opened");
	svc_close_a: assert property (eos_req && !svc_in.start |=> !svc_active && eos_pulse)
		else $error("context not closed");
	eos_cause_a: assert property (eos_pulse |-> $past(eos_req))
		else $error("end of service pulse without cause");
	// ==========
	// per-channel writes
	rate_wr_a: assert property (is_wr && host_req.addr == 7'h78 |=>
		cfg_wr.valid && cfg_wr.offset == 7'h78 && cfg_wr.chan == $past(chan_select) &&
		cfg_wr.data == $past(host_req.wdata))
		else $error("rate period write lost");
	ro_wr_a: assert property (is_wr && host_req.addr == 7'h0B |=> !cfg_wr.valid)
		else $error("read-only write took effect");
endmodule
bind qcrb_top qcrb_top_sva #(.FIRMWARE_CODE(FIRMWARE_CODE)) chk (.clk, .rstn, .host_req,
	.host_rdata, .host_rdata_valid, .svc_in, .svc_active, .eos_pulse, .chan_select,
	.chan0_parallel, .cfg_wr);
`default_nettype wire

/* File: tb/qcrb_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module qcrb_top_tb;
	import qcrb_pkg::*;
	logic clk, rstn, host_rdata_valid, svc_active, eos_pulse, tx_data_valid, rx_pop;
	logic chan0_parallel;
	logic [7:0] host_rdata, rx_data, tx_data, printer_pins, prescaler_period;
	logic [1:0] chan_select;
	logic [2:0] svc_pending;
	logic [31:0] chan_status, chan_rx_count;
	logic [15:0] modem_pins;
	qcrb_req_t host_req;
	qcrb_svc_t svc_in;
	qcrb_cfg_wr_t cfg_wr;
	int n_errors, num_checks, cyc, n_pops;
	qcrb_top uut (
		.clk(clk),
		.rstn(rstn),
		.host_req(host_req),
		.host_rdata(host_rdata),
		.host_rdata_valid(host_rdata_valid),
		.svc_in(svc_in),
		.svc_pending(svc_pending),
		.rx_data(rx_data),
		.chan_status(chan_status),
		.chan_rx_count(chan_rx_count),
		.modem_pins(modem_pins),
		.printer_pins(printer_pins),
		.svc_active(svc_active),
		.eos_pulse(eos_pulse),
		.tx_data_valid(tx_data_valid),
		.tx_data(tx_data),
		.rx_pop(rx_pop),
		.chan_select(chan_select),
		.chan0_parallel(chan0_parallel),
		.prescaler_period(prescaler_period),
		.cfg_wr(cfg_wr)
	);
	qcrb_host host (
		.clk(clk),
		.host_req(host_req),
		.host_rdata(host_rdata),
		.host_rdata_valid(host_rdata_valid)
	);
	// rx pops last one cycle, so count them at the settled falling edge
	always @(negedge clk) begin
		if (rx_pop === 1'b1) n_pops++;
	end
	// ==========
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			finish_test();
		end
	end
	// ==========
	// shared tasks
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		host.rd(a, d);
		chk(nm, e, d);
	endtask
	task automatic svc_go(input qcrb_ctx_t k, input logic [2:0] vec, input logic [3:0] mc);
		@(negedge clk);
		svc_in <= '{start: 1'b1, kind: k, vector: vec, modem_change: mc};
		@(negedge clk);
		svc_in.start <= 1'b0;
	endtask
	// ==========
	// scenarios
	task automatic t_global();
		rdc(7'h40, FIRMWARE_CODE_DEFAULT, "firmware");
		host.wr(7'h40, 8'h3C);
		rdc(7'h40, FIRMWARE_CODE_DEFAULT, "firmware kept");
		for (int i = 0; i < 3; i++) host.wr(7'h44 + 7'(i), 8'h11 * 8'(i + 1));
		host.wr(7'h7E, 8'h9C);
		host.wr(7'h68, 8'h03);
		for (int i = 0; i < 3; i++) rdc(7'h44 + 7'(i), 8'h11 * 8'(i + 1), "int channel");
		rdc(7'h67, 8'h05, "pending");
		chk("prescaler", 8'h9C, prescaler_period);
	endtask
	// each bank gets its own values, read back in reverse order
	task automatic t_banks();
		for (int c = 0; c < NUM_CHANNELS; c++) begin
			host.wr(7'h68, 8'(c));
			host.wr(7'h78, 8'h10 + 8'(c));
			host.wr(7'h72, 8'h20 + 8'(c));
		end
		for (int c = NUM_CHANNELS - 1; c >= 0; c--) begin
			host.wr(7'h68, 8'(c));
			rdc(7'h78, 8'h10 + 8'(c), "rx rate");
			rdc(7'h72, 8'h20 + 8'(c), "tx rate");
			rdc(7'h0B, chan_status[8*c+:8], "ctl status");
			rdc(7'h0E, chan_rx_count[8*c+:8], "rx count");
		end
		host.wr(7'h44, 8'h77);
		host.wr(7'h0B, 8'hEE);
		rdc(7'h78, 8'h10, "rx rate held");
		rdc(7'h0B, chan_status[7:0], "status kept");
	endtask
	task automatic t_virtual();
		rdc(7'h43, 8'h00, "vector idle");
		svc_go(QCRB_CTX_RX, 3'h5, 4'h0);
		rdc(7'h43, 8'h05, "rx vector");
		host.wr(7'h43, 8'hFF);
		rdc(7'h43, 8'h05, "rx vector kept");
		rdc(7'h42, 8'h00, "tx vector off");
		rdc(7'h62, rx_data, "rx data");
		chk("rx pop", 8'h01, 8'(n_pops));
		host.wr(7'h60, 8'h00);
		chk("eos", 8'h01, {7'h0, eos_pulse});
		chk("active", 8'h00, {7'h0, svc_active});
		rdc(7'h43, 8'h00, "vector closed");
		svc_go(QCRB_CTX_MODEM, 3'h2, 4'hA);
		rdc(7'h41, 8'h02, "modem vector");
		rdc(7'h4C, 8'hA0, "modem status");
		rdc(7'h62, 8'h00, "rx data off");
		chk("rx pop off", 8'h01, 8'(n_pops));
		rdc(7'h60, 8'h00, "eos read");
		host.wr(7'h60, 8'h00);
		svc_go(QCRB_CTX_TX, 3'h1, 4'h0);
		rdc(7'h42, 8'h01, "tx vector");
		host.wr(7'h63, 8'h5A);
		chk("tx valid", 8'h01, {7'h0, tx_data_valid});
		chk("tx data", 8'h5A, tx_data);
		host.wr(7'h60, 8'h00);
		host.wr(7'h63, 8'hA5);
		chk("tx valid off", 8'h00, {7'h0, tx_data_valid});
	endtask
	// channel 0 follows the mode bit, channel 1 never does
	task automatic t_parallel();
		host.wr(7'h4B, 8'h80);
		chk("parallel", 8'h01, {7'h0, chan0_parallel});
		host.wr(7'h68, 8'h00);
		host.wr(7'h6F, 8'h03);
		rdc(7'h6F, {printer_pins[7:4], 4'h3}, "printer ch0");
		host.wr(7'h68, 8'h01);
		host.wr(7'h6F, 8'h03);
		rdc(7'h6F, 8'h03, "printer ch1");
		host.wr(7'h6C, 8'h0C);
		rdc(7'h6C, {modem_pins[7:4], 4'hC}, "modem ch1");
		host.wr(7'h4B, 8'h00);
		host.wr(7'h68, 8'h00);
		rdc(7'h6F, 8'h03, "printer serial");
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		n_errors = 0;
		num_checks = 0;
		cyc = 0;
		n_pops = 0;
		rstn = 1'b0;
		svc_in = '0;
		svc_pending = 3'h5;
		rx_data = 8'hC3;
		chan_status = 32'h44332211;
		chan_rx_count = 32'h88776655;
		modem_pins = 16'h4321;
		printer_pins = 8'h50;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		t_global();
		t_banks();
		t_virtual();
		t_parallel();
		finish_test();
	end
endmodule
`default_nettype wire
